/* src/sram_ctrl.sv */
// Purpose: Host controller driving an asynchronous 16-bit static memory
// Assumes: One request at a time; read data settles within a cycle
// Notes: Data bus split into input, output and output enable
`timescale 1ns/10ps
`default_nettype none
`include "sram_ctrl_defs.svh"

module sram_ctrl
    import sram_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = `ADDR_WIDTH_DEF,
    parameter int DATA_WIDTH = `DATA_WIDTH_DEF,
    parameter bit SINGLE_SELECT = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_WIDTH-1:0] req_addr,
    input wire logic [DATA_WIDTH-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    input wire logic retention_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_WIDTH-1:0] rsp_rdata,
    output logic retention_ok,
    output logic [ADDR_WIDTH-1:0] mem_addr,
    output sram_ctl_s mem_ctl,
    input wire logic [DATA_WIDTH-1:0] mem_data_in,
    output logic [DATA_WIDTH-1:0] mem_data_out,
    output logic [DATA_WIDTH-1:0] mem_data_oe
);
    // Refuse widths and read timings that the lane split and timer cannot serve
    if (DATA_WIDTH != 16 || ADDR_WIDTH < 1 || ADDR_WIDTH > 32 ||
        (`READ_CYCLES) + 2 > 15) begin : g_bad_param
        $error("sram_ctrl: unsupported parameter");
    end

    localparam cnt_t READ_CNT = cnt_t'(`READ_CYCLES);
    localparam cnt_t WRITE_CNT = cnt_t'(`WRITE_CYCLES);
    localparam cnt_t SETUP_CNT = cnt_t'(`SETUP_CYCLES);
    localparam cnt_t RECOVER_CNT = cnt_t'(`RECOVERY_CYCLES);
    localparam int HALF = DATA_WIDTH / 2;

    sram_state_e state_reg;
    logic [DATA_WIDTH-1:0] rd_sync1_reg;
    logic [DATA_WIDTH-1:0] rd_sync2_reg;
    logic [1:0] lanes_reg;
    logic load;
    cnt_t load_value;
    logic timer_done;

    cycle_timer #(.WIDTH(4)) phase_timer (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .load(load),
        .value(load_value),
        .done(timer_done)
    );

    // Timer loads on each phase entry except ST_WR_END and the return to ST_IDLE
    always_comb begin
        load = 1'b0;
        load_value = '0;
        unique case (state_reg)
            ST_IDLE: begin
                if (req_valid && !retention_req) begin
                    load = 1'b1;
                    load_value = SETUP_CNT;
                end
            end
            ST_RD_SETUP: begin
                load = 1'b1;
                load_value = READ_CNT + cnt_t'(2);
            end
            ST_WR_SETUP: begin
                load = 1'b1;
                load_value = WRITE_CNT;
            end
            ST_RD_WAIT, ST_WR_END: begin
                if (timer_done) begin
                    load = 1'b1;
                    load_value = RECOVER_CNT;
                end
            end
            ST_WR_PULSE, ST_RECOVER: begin
                load = 1'b0;
            end
        endcase
    end

    // Access sequencing
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else if (ce) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_valid && !retention_req) begin
                        state_reg <= req_write ? ST_WR_SETUP : ST_RD_SETUP;
                    end
                end
                ST_RD_SETUP: state_reg <= ST_RD_WAIT;
                ST_RD_WAIT: begin
                    if (timer_done) begin
                        state_reg <= ST_RECOVER;
                    end
                end
                ST_WR_SETUP: state_reg <= ST_WR_PULSE;
                ST_WR_PULSE: begin
                    if (timer_done) begin
                        state_reg <= ST_WR_END;
                    end
                end
                ST_WR_END: state_reg <= ST_RECOVER;
                ST_RECOVER: begin
                    if (timer_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Address and lanes latched with the request, before select
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mem_addr <= '0;
            lanes_reg <= 2'h0;
            mem_data_out <= '0;
        end else if (ce && state_reg == ST_IDLE && req_valid &&
                     !retention_req) begin
            mem_addr <= req_addr;
            lanes_reg <= req_lanes;
            mem_data_out <= req_wdata;
        end
    end

    // Control strobes; select asserted one cycle after address
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mem_ctl <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        end else if (ce) begin
            mem_ctl <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            unique case (state_reg)
                ST_RD_SETUP, ST_RD_WAIT: begin
                    if (!(state_reg == ST_RD_WAIT && timer_done)) begin
                        mem_ctl.chip_select_active_low <= 1'b0;
                        mem_ctl.chip_select_active_high <= !SINGLE_SELECT;
                        mem_ctl.write_strobe_n <= 1'b1;
                        mem_ctl.output_gate_n <= 1'b0;
                        mem_ctl.lower_byte_select_n <= !lanes_reg[0];
                        mem_ctl.upper_byte_select_n <= !lanes_reg[1];
                    end
                end
                ST_WR_SETUP, ST_WR_PULSE: begin
                    if (!(state_reg == ST_WR_PULSE && timer_done)) begin
                        mem_ctl.chip_select_active_low <= 1'b0;
                        mem_ctl.chip_select_active_high <= !SINGLE_SELECT;
                        mem_ctl.write_strobe_n <= 1'b0;
                        mem_ctl.output_gate_n <= 1'b1;
                        mem_ctl.lower_byte_select_n <= !lanes_reg[0];
                        mem_ctl.upper_byte_select_n <= !lanes_reg[1];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Data drive held two cycles past the write end edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mem_data_oe <= '0;
        end else if (ce) begin
            if (state_reg == ST_WR_SETUP || state_reg == ST_WR_PULSE ||
                state_reg == ST_WR_END) begin
                mem_data_oe <= {{HALF{lanes_reg[1]}}, {HALF{lanes_reg[0]}}};
            end else begin
                mem_data_oe <= '0;
            end
        end
    end

    // Read data synchroniser
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_sync1_reg <= '0;
            rd_sync2_reg <= '0;
        end else if (ce) begin
            rd_sync1_reg <= mem_data_in;
            rd_sync2_reg <= rd_sync1_reg;
        end
    end

    // Response and handshake
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            req_ready <= 1'b0;
            retention_ok <= 1'b0;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            if (state_reg == ST_RD_WAIT && timer_done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= rd_sync2_reg;
            end else if (state_reg == ST_WR_END) begin
                rsp_valid <= 1'b1;
            end
            req_ready <= (state_reg == ST_IDLE) && !req_valid;
            retention_ok <= (state_reg == ST_IDLE) && retention_req;
        end
    end
endmodule
`default_nettype wire

/* inc/sram_ctrl_defs.svh */
// Purpose: Constants for the asynchronous static memory controller
// Assumes: 20 MHz controller clock
// Notes: Times in ns, cycle counts derived from them
`ifndef SRAM_CTRL_DEFS_SVH
`define SRAM_CTRL_DEFS_SVH
`define CLK_PERIOD_NS 50
`define READ_CYCLE_TIME_NS 10
`define WRITE_PULSE_NS 7
`define DATA_SETUP_NS 6
`define RECOVERY_INTERVAL_NS 10
`define DESELECT_TO_RETENTION_GAP_NS 0
`define CYC_UP(t) ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
    (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define READ_CYCLES `CYC_UP(`READ_CYCLE_TIME_NS)
`define WRITE_CYCLES `CYC_UP(`WRITE_PULSE_NS)
`define SETUP_CYCLES `CYC_UP(`DATA_SETUP_NS)
`define RECOVERY_CYCLES `CYC_UP(`RECOVERY_INTERVAL_NS)
`define ADDR_WIDTH_DEF 20
`define DATA_WIDTH_DEF 16
`endif

/* inc/sram_ctrl_pkg.sv */
// Purpose: Types for the static memory controller
// Assumes: Constants come from sram_ctrl_defs.svh
// Notes: Pin group carries the memory's control strobes
package sram_ctrl_pkg;
    typedef struct packed {
        logic chip_select_active_low;
        logic chip_select_active_high;
        logic write_strobe_n;
        logic output_gate_n;
        logic lower_byte_select_n;
        logic upper_byte_select_n;
    } sram_ctl_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_SETUP, ST_RD_WAIT, ST_WR_SETUP, ST_WR_PULSE,
        ST_WR_END, ST_RECOVER
    } sram_state_e;

    typedef logic [3:0] cnt_t;
endpackage

/* src/cycle_timer.sv */
// Purpose: Down counter that times one phase of a memory access
// Assumes: load and clock enable come from the same clock domain
// Notes: done is high when the count has expired
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [WIDTH-1:0] value,
    output logic done
);
    logic [WIDTH-1:0] count_reg;

    if (WIDTH < 1) begin : g_bad_width
        $error("cycle_timer: width below one");
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else if (ce) begin
            if (load) begin
                count_reg <= value;
            end else if (count_reg != '0) begin
                count_reg <= count_reg - WIDTH'(1);
            end
        end
    end

    assign done = (count_reg == '0);
endmodule
`default_nettype wire

/* tb/sram_model.sv */
// Purpose: Behavioural memory facing the controller
// Assumes: Only the low 8 address bits are decoded
// Notes: Undriven lanes show the inverse of the stored byte
`timescale 1ns/10ps
`default_nettype none
module sram_model
    import sram_ctrl_pkg::*;
#(
    parameter bit SINGLE_SELECT = 1'b0
) (
    input wire logic [19:0] addr,
    input wire sram_ctl_s ctl,
    input wire logic [15:0] dout,
    input wire logic [15:0] doe,
    output logic [15:0] din
);
    logic [15:0] mem [0:255];
    logic [15:0] drv;
    logic [15:0] lane;
    logic sel;
    // Single-select variant decodes the low select alone
    assign sel = !ctl.chip_select_active_low &&
        (SINGLE_SELECT || ctl.chip_select_active_high);
    assign lane = {{8{!ctl.upper_byte_select_n}}, {8{!ctl.lower_byte_select_n}}};
    always @* begin
        if (sel && !ctl.write_strobe_n)
            mem[addr[7:0]] = (dout & lane) | (mem[addr[7:0]] & ~lane);
    end
    always_comb begin
        if (sel && !ctl.output_gate_n && ctl.write_strobe_n)
            drv = mem[addr[7:0]] ^ ~lane;
        else
            drv = ~mem[addr[7:0]];
        din = (doe & dout) | (~doe & drv);
    end
endmodule
`default_nettype wire

/* tb/sram_ctrl_sva.sv */
// Purpose: Pin protocol checks on the memory controller
// Assumes: Single clock domain
// Notes: Bound to every controller instance
`timescale 1ns/10ps
`default_nettype none
module sram_ctrl_sva
    import sram_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = 20,
    parameter int DATA_WIDTH = 16,
    parameter bit SINGLE_SELECT = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [1:0] req_lanes,
    input wire logic retention_ok,
    input wire logic [ADDR_WIDTH-1:0] mem_addr,
    input wire sram_ctl_s mem_ctl,
    input wire logic [DATA_WIDTH-1:0] mem_data_oe
);
    default clocking
        @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    logic sel;
    logic we;
    assign sel = !mem_ctl.chip_select_active_low
        && mem_ctl.chip_select_active_high;
    assign we = !mem_ctl.write_strobe_n;
    property p_wr_start;
        we |-> sel && !(mem_ctl.lower_byte_select_n
            && mem_ctl.upper_byte_select_n);
    endproperty
    a_wr_start: assert property (p_wr_start) else $error("write start");
    property p_wr_lanes;
        we |-> {mem_ctl.upper_byte_select_n,
            mem_ctl.lower_byte_select_n} == ~req_lanes;
    endproperty
    a_wr_lanes: assert property (p_wr_lanes) else $error("lanes");
    property p_wr_data;
        we |-> mem_data_oe == {{8{req_lanes[1]}}, {8{req_lanes[0]}}};
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("data drive");
    property p_wr_hold;
        $rose(mem_ctl.write_strobe_n) |-> $stable(mem_data_oe);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("data hold");
    property p_wr_float;
        $rose(mem_ctl.write_strobe_n) |-> mem_ctl.output_gate_n [*2];
    endproperty
    a_wr_float: assert property (p_wr_float) else $error("gate");
    property p_rd_we;
        !mem_ctl.output_gate_n |-> !we && mem_data_oe == '0;
    endproperty
    a_rd_we: assert property (p_rd_we) else $error("read strobe");
    property p_addr;
        sel |-> $stable(mem_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("address");
    property p_ret;
        retention_ok |-> !sel;
    endproperty
    a_ret: assert property (p_ret) else $error("retention");
    property p_sel_pair;
        mem_ctl.chip_select_active_high ==
            (!mem_ctl.chip_select_active_low && !SINGLE_SELECT);
    endproperty
    a_sel_pair: assert property (p_sel_pair) else $error("select pair");
    c_write: cover property (we);
    c_read: cover property (!mem_ctl.output_gate_n);
    c_ret: cover property (retention_ok);
endmodule
bind sram_ctrl sram_ctrl_sva #(.ADDR_WIDTH(ADDR_WIDTH),
    .DATA_WIDTH(DATA_WIDTH), .SINGLE_SELECT(SINGLE_SELECT))
    sram_ctrl_sva_inst (.mclk, .rstn, .req_lanes,
    .retention_ok, .mem_addr, .mem_ctl, .mem_data_oe);
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Directed tests of the memory controller
// Assumes: Memory model on the pin side
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import sram_ctrl_pkg::*;
    logic mclk, rstn, ce, req_valid, req_write, retention_req;
    logic req_ready, rsp_valid, retention_ok;
    logic [19:0] req_addr, mem_addr;
    logic [15:0] req_wdata, rsp_rdata, mem_data_in, mem_data_out;
    logic [15:0] mem_data_oe, rd;
    logic [1:0] req_lanes;
    sram_ctl_s mem_ctl;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    sram_ctrl sram_ctrl_inst (.mclk, .rstn, .ce, .req_valid,
        .req_write, .req_addr, .req_wdata, .req_lanes, .retention_req,
        .req_ready, .rsp_valid, .rsp_rdata, .retention_ok, .mem_addr,
        .mem_ctl, .mem_data_in, .mem_data_out, .mem_data_oe);
    sram_model #(.SINGLE_SELECT(1'b0)) sram_model_inst (.addr(mem_addr),
        .ctl(mem_ctl), .dout(mem_data_out), .doe(mem_data_oe),
        .din(mem_data_in));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic acc(logic w, logic [19:0] a, logic [15:0] d,
        logic [1:0] ln);
        int n = 0;
        {req_write, req_addr, req_wdata, req_lanes} = {w, a, d, ln};
        req_valid = 1'b1;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (rsp_valid !== 1'b1 && n < 20);
        chk("rsp_valid", 1'b1, rsp_valid);
        rd = rsp_rdata;
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
        chk("rsp_pulse", 1'b0, rsp_valid);
    endtask
    task automatic t_idle();
        @(posedge mclk);
        #1;
        chk("cs_low", 1'b1, mem_ctl.chip_select_active_low);
        chk("data_oe", 16'h0, mem_data_oe);
        chk("ret_ok", 1'b0, retention_ok);
        chk("req_ready", 1'b1, req_ready);
        $display("Done idle");
    endtask
    task automatic t_lanes();
        acc(1'b1, 20'h00010, 16'h1234, 2'h3);
        acc(1'b0, 20'h00010, 16'h0000, 2'h3);
        chk("word", 16'h1234, rd);
        acc(1'b1, 20'h00010, 16'hff56, 2'h1);
        acc(1'b1, 20'h00010, 16'h78ff, 2'h2);
        acc(1'b0, 20'h00010, 16'h0000, 2'h3);
        chk("merged", 16'h7856, rd);
        acc(1'b0, 20'h00010, 16'h0000, 2'h1);
        chk("lower", 16'h0056, rd & 16'h00ff);
        acc(1'b0, 20'h00010, 16'h0000, 2'h2);
        chk("upper", 16'h7800, rd & 16'hff00);
        $display("Done lanes");
    endtask
    task automatic t_b2b();
        logic [19:0] al [3] = '{20'h00020, 20'hfffff, 20'h00021};
        foreach (al[i])
            acc(1'b1, al[i], {al[i][7:0], ~al[i][7:0]}, 2'h3);
        foreach (al[i]) begin
            acc(1'b0, al[i], 16'h0000, 2'h3);
            chk("b2b", {al[i][7:0], ~al[i][7:0]}, rd);
        end
        $display("Done back to back");
    endtask
    task automatic t_ret();
        int n = 0;
        retention_req = 1'b1;
        {req_write, req_addr, req_wdata, req_lanes} = {21'h100030, 18'h03c3f};
        req_valid = 1'b1;
        repeat (10) begin
            @(posedge mclk);
            #1;
            n += (rsp_valid !== 1'b0 || !mem_ctl.chip_select_active_low);
        end
        chk("refused", 16'h0, n[15:0]);
        chk("ret_ok", 1'b1, retention_ok);
        retention_req = 1'b0;
        acc(1'b1, 20'h00030, 16'h0f0f, 2'h3);
        acc(1'b0, 20'h00030, 16'h0000, 2'h3);
        chk("after", 16'h0f0f, rd);
        $display("Done retention");
    endtask
    task automatic t_freeze();
        sram_ctl_s held;
        acc(1'b1, 20'h00040, 16'hbeef, 2'h3);
        req_write = 1'b0;
        req_valid = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        held = mem_ctl;
        ce = 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk("frozen_ctl", 16'(held), 16'(mem_ctl));
        chk("frozen_rsp", 1'b0, rsp_valid);
        chk("read_gate", 1'b0, held.output_gate_n);
        ce = 1'b1;
        acc(1'b0, 20'h00040, 16'h0000, 2'h3);
        chk("resumed", 16'hbeef, rd);
        $display("Done freeze");
    endtask
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        req_valid = 1'b0;
        retention_req = 1'b0;
        {req_write, req_addr, req_wdata, req_lanes} = '0;
        repeat (4) @(posedge mclk);
        #1;
        rstn = 1'b1;
        t_idle();
        t_lanes();
        t_b2b();
        t_ret();
        t_freeze();
        stop_test();
    end
endmodule
`default_nettype wire
